// >>> core/fmx_pkg.sv
package fmx_pkg;
   // Channel and fault module population
   localparam int NUM_CH = 4;
   localparam int NUM_FM = 4;
   localparam int FM_CBC = 0;
   localparam int FM_AB = 1;
   localparam int FM_A = 2;
   localparam int FM_B = 3;

   // Fault source population
   localparam int NUM_DC = 4;
   localparam int NUM_AC = 7;
   localparam int NUM_PIN = 4;
   localparam int NUM_CHF = 5;

   // Bit offsets of each source group in the flat source vector
   localparam int SRC_DC = 0;
   localparam int SRC_AC = SRC_DC + NUM_DC;
   localparam int SRC_PIN = SRC_AC + NUM_AC;
   localparam int SRC_CHF = SRC_PIN + NUM_PIN;
   localparam int SRC_HFO = SRC_CHF + NUM_CH * NUM_CHF;
   localparam int SRC_LFO = SRC_HFO + 1;
   localparam int SRC_DCM = SRC_LFO + 1;
   localparam int NUM_SRC = SRC_DCM + 1;

   // Default widths
   localparam int CNT_W = 4;
   localparam int EC_W = 9;
   localparam int ACT_W = 7;

   // Clock failure timeout: longest time, rounded down, at least one cycle
   localparam int CLK_PERIOD_NS = 50;
   localparam int CKF_TIMEOUT_NS = 2000;
   localparam int CKF_TO_CYC = (CKF_TIMEOUT_NS / CLK_PERIOD_NS < 1) ? 1 :
                               CKF_TIMEOUT_NS / CLK_PERIOD_NS;

   // Reset values
   localparam logic FLAG_RST = 1'h0;
   localparam logic [CNT_W:0] CNT_RST = 5'h00;

   // Faults raised by each pwm_channel
   typedef struct packed {
      logic cur_lim;
      logic ovp;
      logic ext_a;
      logic ext_b;
      logic ideal_diode_emulation;
   } fmx_chf_s;
endpackage : fmx_pkg

// >>> core/fmx_fault_mod.sv
`timescale 1ns/100ps
module fmx_fault_mod #(
   parameter int CW = fmx_pkg::CNT_W
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic fault_en,
   input wire logic chan_en,
   input wire logic cyc_start,
   input wire logic fault_in,
   input wire logic [CW-1:0] max_count,
   output logic hit,
   output logic flag_r
);
   logic seen_r;
   logic [CW:0] cnt_r;
   logic [CW:0] cnt_nxt;
   logic [CW:0] base;
   logic seen_nxt;
   logic flag_nxt;
   localparam logic [CW:0] CNT_ZERO = (CW + 1)'(fmx_pkg::CNT_RST);
   wire armed = fault_en & chan_en;
   wire seen_now = cyc_start ? 1'h0 : seen_r;
   wire cnt_sat = &cnt_r;
   wire over = cnt_r > {1'h0, max_count};

   // A new cycle starts clean, the fault still counts in that same cycle
   assign hit = armed & fault_in & ~seen_now;
   assign base = (cyc_start & ~seen_r) ? CNT_ZERO : cnt_r;
   assign seen_nxt = armed & (seen_now | hit);
   assign cnt_nxt = !armed ? CNT_ZERO : (hit & ~cnt_sat) ? base + 1'h1 : base;
   // Only dropping channel_enable releases the flag
   assign flag_nxt = chan_en & (flag_r | (fault_en & over));

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         seen_r <= 1'h0;
         cnt_r <= CNT_ZERO;
         flag_r <= fmx_pkg::FLAG_RST;
      end else begin
         seen_r <= seen_nxt;
         cnt_r <= cnt_nxt;
         flag_r <= flag_nxt;
      end
   end

   property p_once;
      @(posedge clk_sys) disable iff (!nrst) seen_r && !cyc_start |-> !hit;
   endproperty
   a_once: assert property (p_once) else $error("second fault taken in one cycle");

   property p_limit;
      @(posedge clk_sys) disable iff (!nrst)
         $rose(flag_r) |-> $past(cnt_r) > {1'h0, $past(max_count)};
   endproperty
   a_limit: assert property (p_limit) else $error("flag set below count limit");

   property p_run;
      @(posedge clk_sys) disable iff (!nrst)
         armed && cyc_start && !seen_r |=> cnt_r <= 1;
   endproperty
   a_run: assert property (p_run) else $error("run kept across a clean cycle");

   property p_hold;
      @(posedge clk_sys) disable iff (!nrst) flag_r && chan_en |=> flag_r;
   endproperty
   a_hold: assert property (p_hold) else $error("flag lost while enabled");

   property p_clear;
      @(posedge clk_sys) disable iff (!nrst) !chan_en |=> !flag_r && cnt_r == 0;
   endproperty
   a_clear: assert property (p_clear) else $error("flag survived disable");

   property p_gate;
      @(posedge clk_sys) disable iff (!nrst) !fault_en |-> !hit ##1 cnt_r == 0;
   endproperty
   a_gate: assert property (p_gate) else $error("fault taken while disabled");

   c_flag: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(flag_r));
endmodule : fmx_fault_mod

// >>> core/fmx_cbc.sv
`timescale 1ns/100ps
module fmx_cbc (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic chan_en,
   input wire logic cyc_start,
   input wire logic pcm_en,
   input wire logic pcm_trip,
   input wire logic cbc_hit,
   output logic trunc_r
);
   // Truncate the pulse for the rest of the cycle; a new trip wins over the restart
   wire trip = (pcm_en & pcm_trip) | cbc_hit;
   wire trunc_nxt = chan_en & ((trunc_r & ~cyc_start) | trip);

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         trunc_r <= 1'h0;
      end else begin
         trunc_r <= trunc_nxt;
      end
   end

   property p_trip;
      @(posedge clk_sys) disable iff (!nrst) chan_en && trip |=> trunc_r;
   endproperty
   a_trip: assert property (p_trip) else $error("trip did not truncate");

   c_trunc: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(trunc_r));
endmodule : fmx_cbc

// >>> core/fmx_fault_mux.sv
`timescale 1ns/100ps
module fmx_fault_mux #(
   parameter int CNT_W = fmx_pkg::CNT_W,
   parameter int EC_W = fmx_pkg::EC_W,
   parameter int ACT_W = fmx_pkg::ACT_W,
   parameter int CKF_CYC = fmx_pkg::CKF_TO_CYC
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic fault_en,
   input wire logic [fmx_pkg::NUM_CH-1:0] channel_enable,
   input wire logic [fmx_pkg::NUM_CH-1:0] cyc_start,
   input wire logic [fmx_pkg::NUM_CH-1:0][fmx_pkg::NUM_FM-1:0][fmx_pkg::NUM_SRC-1:0] route_mask,
   input wire logic [fmx_pkg::NUM_CH-1:0][fmx_pkg::NUM_FM-1:0][CNT_W-1:0] max_count,
   input wire logic [fmx_pkg::NUM_DC-1:0][EC_W-1:0] error_converter_sample,
   input wire logic [fmx_pkg::NUM_DC-1:0][EC_W-1:0] dc_thr,
   input wire logic [fmx_pkg::NUM_DC-1:0] dc_en,
   input wire logic [fmx_pkg::NUM_AC-1:0][ACT_W-1:0] ac_thr,
   input wire logic [fmx_pkg::NUM_AC-1:0] ac_result,
   input wire logic [fmx_pkg::NUM_AC-1:0] ac_pol,
   input wire logic [fmx_pkg::NUM_AC-1:0] ac_en,
   input wire logic [fmx_pkg::NUM_PIN-1:0] fault_pin,
   input wire logic [fmx_pkg::NUM_PIN-1:0] pin_pol,
   input wire logic [fmx_pkg::NUM_PIN-1:0] pin_en,
   input fmx_pkg::fmx_chf_s [fmx_pkg::NUM_CH-1:0] chf_in,
   input fmx_pkg::fmx_chf_s [fmx_pkg::NUM_CH-1:0] chf_en,
   input wire logic [1:0] osc_tick,
   input wire logic [1:0] ckf_en,
   input wire logic [EC_W-1:0] discontinuous_conduction_sample,
   input wire logic [EC_W-1:0] dcm_thr,
   input wire logic dcm_en,
   input wire logic [fmx_pkg::NUM_CH-1:0] pcm_en,
   input wire logic [fmx_pkg::NUM_CH-1:0] pcm_trip,
   output logic [fmx_pkg::NUM_CH-1:0][fmx_pkg::NUM_FM-1:0] fm_flag,
   output logic [fmx_pkg::NUM_CH-1:0] cycle_by_cycle_trunc,
   output logic [fmx_pkg::NUM_CH-1:0] off_a_r,
   output logic [fmx_pkg::NUM_CH-1:0] off_b_r,
   output logic [fmx_pkg::NUM_AC-1:0][ACT_W-1:0] ac_thr_r,
   output logic [1:0] ckf_r,
   output logic dcm_r,
   output logic [fmx_pkg::NUM_SRC-1:0] src_stat_r
);
   localparam int NCH = fmx_pkg::NUM_CH;
   localparam int NFM = fmx_pkg::NUM_FM;
   localparam int NSRC = fmx_pkg::NUM_SRC;
   localparam int NCHF = fmx_pkg::NUM_CHF;
   localparam int CKW = $clog2(CKF_CYC + 1);
   localparam logic [CKW-1:0] CKF_LAST = CKW'(CKF_CYC);

   logic [fmx_pkg::NUM_DC-1:0] dc_flt_r;
   logic [fmx_pkg::NUM_AC-1:0] ac_flt;
   logic [fmx_pkg::NUM_PIN-1:0] pin_flt;
   logic [NCH*NCHF-1:0] chf_flt;
   logic [NSRC-1:0] src;
   logic [1:0] osc_q_r;
   logic [1:0][CKW-1:0] ckf_cnt_r;
   logic [NCH-1:0][NFM-1:0] fm_hit;
   logic [NCH-1:0][NFM-1:0] fm_in;
   logic [NCH-1:0] off_a_nxt;
   logic [NCH-1:0] off_b_nxt;

   // Digital comparators on error converter samples, one cycle of latency
   genvar d;
   generate
      for (d = 0; d < fmx_pkg::NUM_DC; d++) begin : g_dc
         wire over = error_converter_sample[d] > dc_thr[d];
         always_ff @(posedge clk_sys) begin
            if (!nrst) begin
               dc_flt_r[d] <= 1'h0;
            end else begin
               dc_flt_r[d] <= dc_en[d] & over;
            end
         end
      end
   endgenerate

   // Analog comparators and pins pass without a flop so that detection is immediate
   assign ac_flt = ac_en & (ac_result ^ ac_pol);
   assign pin_flt = pin_en & (fault_pin ^ pin_pol);

   genvar f;
   generate
      for (f = 0; f < NCH; f++) begin : g_chf
         assign chf_flt[f*NCHF +: NCHF] = chf_in[f] & chf_en[f];
      end
   endgenerate

   // Thresholds go out to the comparator references through a flop
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         ac_thr_r <= '0;
      end else begin
         ac_thr_r <= ac_thr;
      end
   end

   // Oscillator watchdog: no edge on the tick for the timeout means a failure.
   // The tick must be a divided oscillator slow enough to be sampled at clk_sys.
   genvar k;
   generate
      for (k = 0; k < 2; k++) begin : g_ckf
         wire edge_seen = osc_tick[k] ^ osc_q_r[k];
         wire at_last = ckf_cnt_r[k] == CKF_LAST;
         always_ff @(posedge clk_sys) begin
            if (!nrst) begin
               osc_q_r[k] <= 1'h0;
               ckf_cnt_r[k] <= '0;
               ckf_r[k] <= 1'h0;
            end else begin
               osc_q_r[k] <= osc_tick[k];
               ckf_cnt_r[k] <= (edge_seen | ~ckf_en[k]) ? '0 :
                               at_last ? ckf_cnt_r[k] : ckf_cnt_r[k] + 1'h1;
               ckf_r[k] <= ckf_en[k] & at_last;
            end
         end
      end
   endgenerate

   // Inductor current sample below threshold means discontinuous conduction
   wire dcm_now = discontinuous_conduction_sample < dcm_thr;

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         dcm_r <= 1'h0;
      end else begin
         dcm_r <= dcm_en & dcm_now;
      end
   end

   assign src = {dcm_r, ckf_r[1], ckf_r[0], chf_flt, pin_flt, ac_flt, dc_flt_r};

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         src_stat_r <= '0;
      end else begin
         src_stat_r <= src;
      end
   end

   // Per channel: four identical fault modules plus one cycle-by-cycle block
   genvar c, m;
   generate
      for (c = 0; c < NCH; c++) begin : g_ch
         for (m = 0; m < NFM; m++) begin : g_fm
            // Any source may feed any module of any channel
            assign fm_in[c][m] = |(src & route_mask[c][m]);
            fmx_fault_mod #(.CW(CNT_W)) u_fm (
               .clk_sys(clk_sys),
               .nrst(nrst),
               .fault_en(fault_en),
               .chan_en(channel_enable[c]),
               .cyc_start(cyc_start[c]),
               .fault_in(fm_in[c][m]),
               .max_count(max_count[c][m]),
               .hit(fm_hit[c][m]),
               .flag_r(fm_flag[c][m])
            );
         end

         fmx_cbc u_cbc (
            .clk_sys(clk_sys),
            .nrst(nrst),
            .chan_en(channel_enable[c]),
            .cyc_start(cyc_start[c]),
            .pcm_en(pcm_en[c]),
            .pcm_trip(pcm_trip[c]),
            .cbc_hit(fm_hit[c][fmx_pkg::FM_CBC]),
            .trunc_r(cycle_by_cycle_trunc[c])
         );

         // Wiring is the only difference between the modules
         wire both = fm_flag[c][fmx_pkg::FM_CBC] | fm_flag[c][fmx_pkg::FM_AB];
         assign off_a_nxt[c] = both | fm_flag[c][fmx_pkg::FM_A];
         assign off_b_nxt[c] = both | fm_flag[c][fmx_pkg::FM_B];
      end
   endgenerate

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         off_a_r <= '0;
         off_b_r <= '0;
      end else begin
         off_a_r <= off_a_nxt;
         off_b_r <= off_b_nxt;
      end
   end

   property p_dc;
      @(posedge clk_sys) disable iff (!nrst)
         dc_en[0] && error_converter_sample[0] > dc_thr[0] |=> dc_flt_r[0];
   endproperty
   a_dc: assert property (p_dc) else $error("digital comparator missed");

   property p_route;
      @(posedge clk_sys) disable iff (!nrst)
         channel_enable[1] && $rose(fm_flag[1][fmx_pkg::FM_A]) |=> off_a_r[1] && !off_b_r[1]
            || fm_flag[1][fmx_pkg::FM_B] || fm_flag[1][fmx_pkg::FM_AB]
            || fm_flag[1][fmx_pkg::FM_CBC];
   endproperty
   a_route: assert property (p_route) else $error("A module shut the wrong output");

   property p_ckf;
      @(posedge clk_sys) disable iff (!nrst)
         ckf_en[0] && ckf_cnt_r[0] == CKF_LAST |=> ckf_r[0];
   endproperty
   a_ckf: assert property (p_ckf) else $error("clock failure not flagged");

   property p_dcm;
      @(posedge clk_sys) disable iff (!nrst)
         dcm_en && dcm_now |=> dcm_r ##1 src_stat_r[fmx_pkg::SRC_DCM];
   endproperty
   a_dcm: assert property (p_dcm) else $error("conduction detector missed");

   // Source paths are checked at the status copy, one cycle after the fault
   property p_ac;
      @(posedge clk_sys) disable iff (!nrst)
         ac_en[0] && (ac_result[0] != ac_pol[0]) |=> src_stat_r[fmx_pkg::SRC_AC];
   endproperty
   a_ac: assert property (p_ac) else $error("analog comparator fault lost");

   property p_thr;
      @(posedge clk_sys) disable iff (!nrst) 1'b1 |=> ac_thr_r == $past(ac_thr);
   endproperty
   a_thr: assert property (p_thr) else $error("threshold not passed on");

   property p_pin;
      @(posedge clk_sys) disable iff (!nrst)
         pin_en[0] && (fault_pin[0] != pin_pol[0]) |=> src_stat_r[fmx_pkg::SRC_PIN];
   endproperty
   a_pin: assert property (p_pin) else $error("pin fault lost");

   property p_chf;
      @(posedge clk_sys) disable iff (!nrst)
         chf_in[0].cur_lim && chf_en[0].cur_lim |=> src_stat_r[fmx_pkg::SRC_CHF + 4];
   endproperty
   a_chf: assert property (p_chf) else $error("channel fault lost");

   property p_lfo;
      @(posedge clk_sys) disable iff (!nrst)
         ckf_en[1] && ckf_cnt_r[1] == CKF_LAST |=> ckf_r[1];
   endproperty
   a_lfo: assert property (p_lfo) else $error("slow clock failure not flagged");

   property p_any;
      @(posedge clk_sys) disable iff (!nrst)
         fault_en && channel_enable[2] && cyc_start[2] && ac_flt[0]
            && route_mask[2][fmx_pkg::FM_B][fmx_pkg::SRC_AC] |-> fm_hit[2][fmx_pkg::FM_B];
   endproperty
   a_any: assert property (p_any) else $error("selected source did not trigger");

   property p_fan;
      @(posedge clk_sys) disable iff (!nrst)
         fault_en && channel_enable[0] && channel_enable[3] && cyc_start[0] && cyc_start[3]
            && pin_flt[0] && route_mask[0][fmx_pkg::FM_AB][fmx_pkg::SRC_PIN]
            && route_mask[3][fmx_pkg::FM_AB][fmx_pkg::SRC_PIN]
            |-> fm_hit[0][fmx_pkg::FM_AB] && fm_hit[3][fmx_pkg::FM_AB];
   endproperty
   a_fan: assert property (p_fan) else $error("shared source missed a channel");

   property p_gate_all;
      @(posedge clk_sys) disable iff (!nrst) !fault_en |-> fm_hit == '0;
   endproperty
   a_gate_all: assert property (p_gate_all) else $error("module hit while disabled");

   property p_cbc;
      @(posedge clk_sys) disable iff (!nrst)
         channel_enable[0] && fm_hit[0][fmx_pkg::FM_CBC] |=> cycle_by_cycle_trunc[0];
   endproperty
   a_cbc: assert property (p_cbc) else $error("module hit did not truncate");

   property p_pcm;
      @(posedge clk_sys) disable iff (!nrst)
         !pcm_en[1] && !fm_hit[1][fmx_pkg::FM_CBC] && !cycle_by_cycle_trunc[1]
            |=> !cycle_by_cycle_trunc[1];
   endproperty
   a_pcm: assert property (p_pcm) else $error("truncation without a trip");

   property p_both;
      @(posedge clk_sys) disable iff (!nrst)
         fm_flag[0][fmx_pkg::FM_CBC] |=> off_a_r[0] && off_b_r[0];
   endproperty
   a_both: assert property (p_both) else $error("cycle module left an output on");

   property p_offb;
      @(posedge clk_sys) disable iff (!nrst)
         fm_flag[2][fmx_pkg::FM_B] |=> off_b_r[2];
   endproperty
   a_offb: assert property (p_offb) else $error("B module did not shut output B");

   property p_drop;
      @(posedge clk_sys) disable iff (!nrst)
         !channel_enable[3] |=> fm_flag[3] == '0 ##1 (!off_a_r[3] && !off_b_r[3]);
   endproperty
   a_drop: assert property (p_drop) else $error("channel flags not cleared together");

   c_ckf: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(ckf_r[1]));
   c_all: cover property (@(posedge clk_sys) disable iff (!nrst) &fm_flag[0]);
   c_off: cover property (@(posedge clk_sys) disable iff (!nrst) off_a_r[3] && off_b_r[3]);
endmodule : fmx_fault_mux

// >>> sim/fmx_pwm_model.sv
`timescale 1ns/100ps
module fmx_pwm_model #(
   parameter int PER = 8
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [3:0] chan_on,
   output logic [3:0] cyc_start
);
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;

   assign cnt_nxt = (cnt_r == 8'(PER - 1)) ? 8'h00 : cnt_r + 8'h01;

   always_ff @(posedge clk_sys) begin
      cnt_r <= nrst ? cnt_nxt : 8'h00;
   end

   // A disabled generator stops marking cycles, as a real channel does
   assign cyc_start = (cnt_r == 8'h00 && nrst) ? chan_on : 4'h0;
endmodule : fmx_pwm_model

// >>> sim/fmx_fault_mux_bench.sv
`timescale 1ns/100ps
module fmx_fault_mux_bench;
   localparam int PER = 8;
   localparam logic [fmx_pkg::NUM_SRC-1:0] AC0 = 1 << fmx_pkg::SRC_AC;
   localparam logic [fmx_pkg::NUM_SRC-1:0] PIN0 = 1 << fmx_pkg::SRC_PIN;
   logic clk_sys, nrst, fault_en, dcm_en, tick_run;
   logic [3:0] channel_enable, cyc_start, dc_en, fault_pin, pin_pol, pin_en, pcm_en, pcm_trip;
   logic [3:0][3:0][fmx_pkg::NUM_SRC-1:0] route_mask;
   logic [3:0][3:0][3:0] max_count;
   logic [3:0][8:0] error_converter_sample, dc_thr;
   logic [6:0][6:0] ac_thr, ac_thr_r;
   logic [6:0] ac_result, ac_pol, ac_en;
   fmx_pkg::fmx_chf_s [3:0] chf_in, chf_en;
   logic [1:0] osc_tick, ckf_en, ckf_r;
   logic [8:0] discontinuous_conduction_sample, dcm_thr;
   logic [3:0][3:0] fm_flag;
   logic [3:0] cycle_by_cycle_trunc, off_a_r, off_b_r;
   logic dcm_r;
   logic [fmx_pkg::NUM_SRC-1:0] src_stat_r;
   logic [23:0] exp;
   logic [fmx_pkg::NUM_SRC-1:0] msk;
   int num_errors = 0;
   int check_count = 0;
   int seed = 69853;
   int r, lim;

   fmx_fault_mux #(.CKF_CYC(4)) dut (.clk_sys(clk_sys), .nrst(nrst), .fault_en(fault_en),
      .channel_enable(channel_enable), .cyc_start(cyc_start), .route_mask(route_mask),
      .max_count(max_count), .error_converter_sample(error_converter_sample),
      .dc_thr(dc_thr), .dc_en(dc_en), .ac_thr(ac_thr), .ac_result(ac_result),
      .ac_pol(ac_pol), .ac_en(ac_en), .fault_pin(fault_pin), .pin_pol(pin_pol),
      .pin_en(pin_en), .chf_in(chf_in), .chf_en(chf_en), .osc_tick(osc_tick),
      .ckf_en(ckf_en), .discontinuous_conduction_sample(discontinuous_conduction_sample),
      .dcm_thr(dcm_thr), .dcm_en(dcm_en), .pcm_en(pcm_en), .pcm_trip(pcm_trip),
      .fm_flag(fm_flag), .cycle_by_cycle_trunc(cycle_by_cycle_trunc), .off_a_r(off_a_r),
      .off_b_r(off_b_r), .ac_thr_r(ac_thr_r), .ckf_r(ckf_r), .dcm_r(dcm_r),
      .src_stat_r(src_stat_r));

   fmx_pwm_model #(.PER(PER)) pwm (.clk_sys(clk_sys), .nrst(nrst),
      .chan_on(channel_enable), .cyc_start(cyc_start));

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // Oscillator ticks keep toggling unless a clock failure is being staged
   always @(posedge clk_sys) begin
      osc_tick <= tick_run ? ~osc_tick : osc_tick;
   end

   function automatic logic f_flag(input int run, input int limit);
      return run > limit;
   endfunction : f_flag

   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_sim

   task automatic chk_flag(input logic [23:0] exp_v);
      check_count++;
      if ({off_b_r, off_a_r, fm_flag} !== exp_v) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time,
                  {off_b_r, off_a_r, fm_flag}, exp_v);
      end
   endtask : chk_flag

   task automatic chk_vec(input logic [63:0] got, input logic [63:0] exp_v);
      check_count++;
      if (got !== exp_v) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp_v);
      end
   endtask : chk_vec

   task automatic wait_cyc();
      int n;
      for (n = 0; n < 4 * PER; n++) begin
         @(negedge clk_sys);
         if (cyc_start[0] === 1'b1) begin
            break;
         end
      end
      if (n == 4 * PER) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
         end_sim();
      end
      @(posedge clk_sys);
   endtask : wait_cyc

   // Fault stays clear of the closing cycle start, so exactly run cycles see it
   task automatic run_fault(input int run);
      wait_cyc();
      ac_result[0] <= 1'b1;
      repeat (run * PER - 2) @(posedge clk_sys);
      ac_result[0] <= 1'b0;
      repeat (2 * PER + 4) @(posedge clk_sys);
   endtask : run_fault

   task automatic set_all(input int limit, input logic [fmx_pkg::NUM_SRC-1:0] src);
      for (int c = 0; c < 4; c++) begin
         for (int m = 0; m < 4; m++) begin
            max_count[c][m] <= 4'(limit);
            route_mask[c][m] <= src;
         end
      end
   endtask : set_all

   task automatic chan_clear();
      channel_enable <= 4'h0;
      repeat (3) @(posedge clk_sys);
      chk_flag(24'h00_0000);
      channel_enable <= 4'hf;
   endtask : chan_clear

   initial begin
      nrst = 1'b0; fault_en = 1'b0; dcm_en = 1'b0; tick_run = 1'b1; osc_tick = 2'h0;
      channel_enable = 4'h0; dc_en = 4'h0; fault_pin = 4'h0; pin_pol = 4'h0;
      pin_en = 4'h0; pcm_en = 4'h0; pcm_trip = 4'h0; route_mask = '0; max_count = '0;
      error_converter_sample = '0; dc_thr = '0; ac_thr = '0; ac_result = 7'h00;
      ac_pol = 7'h00; ac_en = 7'h01; chf_in = '0; chf_en = '0; ckf_en = 2'h0;
      discontinuous_conduction_sample = 9'h000; dcm_thr = 9'h000;
      repeat (12) @(posedge clk_sys);
      nrst <= 1'b1;
      fault_en <= 1'b1;
      channel_enable <= 4'hf;
      for (int i = 0; i < 24; i++) begin
         r = (i == 0) ? 1 : (i == 1) ? 3 : 1 + ($unsigned($random(seed)) % 6);
         ac_thr <= 49'($random(seed));
         exp = 24'h00_0000;
         for (int c = 0; c < 4; c++) begin
            for (int m = 0; m < 4; m++) begin
               lim = (i == 0) ? 0 : (i == 1) ? 3 : $unsigned($random(seed)) % 7;
               max_count[c][m] <= 4'(lim);
               msk = ($random(seed) & 1) ? AC0 | PIN0 : PIN0;
               route_mask[c][m] <= msk;
               exp[c * 4 + m] = (i < 2 || msk[fmx_pkg::SRC_AC]) &&
                                f_flag(r, lim);
            end
         end
         if (i < 2) begin
            set_all(lim, AC0 | PIN0);
         end
         @(posedge clk_sys);
         for (int c = 0; c < 4; c++) begin
            exp[16 + c] = exp[c * 4] | exp[c * 4 + 1] | exp[c * 4 + 2];
            exp[20 + c] = exp[c * 4] | exp[c * 4 + 1] | exp[c * 4 + 3];
         end
         run_fault(r);
         chk_flag(exp);
         chan_clear();
      end
      $display("test count_limit done errors %0d", num_errors);
      set_all(3, AC0);
      run_fault(2);
      run_fault(2);
      chk_flag(24'h00_0000);
      run_fault(4);
      chk_flag(24'hff_ffff);
      chan_clear();
      $display("test run_reset done errors %0d", num_errors);
      set_all(0, AC0);
      fault_en <= 1'b0;
      run_fault(4);
      chk_flag(24'h00_0000);
      fault_en <= 1'b1;
      $display("test global_enable done errors %0d", num_errors);
      pcm_en <= 4'h4;
      wait_cyc();
      // Channel 1 trips too, but its peak-current input is off
      pcm_trip <= 4'h6;
      @(posedge clk_sys);
      pcm_trip <= 4'h0;
      repeat (3) @(posedge clk_sys);
      chk_vec(64'(cycle_by_cycle_trunc), 64'h0000_0000_0000_0004);
      repeat (PER + 2) @(posedge clk_sys);
      chk_vec(64'(cycle_by_cycle_trunc), 64'h0000_0000_0000_0000);
      wait_cyc();
      ac_result[0] <= 1'b1;
      @(posedge clk_sys);
      ac_result[0] <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk_vec(64'(cycle_by_cycle_trunc), 64'h0000_0000_0000_000f);
      chan_clear();
      $display("test cycle_trunc done errors %0d", num_errors);
      error_converter_sample[0] <= 9'h100;
      dc_thr[0] <= 9'h010;
      dc_en <= 4'h1;
      ac_result[2] <= 1'b1;
      ac_en[2] <= 1'b1;
      fault_pin <= 4'h0;
      pin_pol <= 4'h2;
      pin_en <= 4'h2;
      chf_in[1].ovp <= 1'b1;
      chf_en[1].ovp <= 1'b1;
      tick_run <= 1'b0;
      ckf_en <= 2'h3;
      discontinuous_conduction_sample <= 9'h005;
      dcm_thr <= 9'h020;
      dcm_en <= 1'b1;
      repeat (14) @(posedge clk_sys);
      exp = 24'h00_0000;
      chk_vec(64'({ckf_r, dcm_r, src_stat_r}), 64'({2'h3, 1'b1,
         (38'h1 << fmx_pkg::SRC_DC) | (38'h1 << (fmx_pkg::SRC_AC + 2)) |
         (38'h1 << (fmx_pkg::SRC_PIN + 1)) | (38'h1 << (fmx_pkg::SRC_CHF + 8)) |
         (38'h1 << fmx_pkg::SRC_HFO) | (38'h1 << fmx_pkg::SRC_LFO) |
         (38'h1 << fmx_pkg::SRC_DCM)}));
      chk_vec(64'(ac_thr_r), 64'(ac_thr));
      $display("test sources done errors %0d", num_errors);
      end_sim();
   end
endmodule : fmx_fault_mux_bench
